// >>> eif_chan.sv
// one source channel: sampling noise canceller and trigger detector
`timescale 1ns/100ps
module eif_chan #(
  parameter bit FIXED   = 1'b0,
  parameter bit HIGH_OK = 1'b0
) (
  input  wire logic    i_ref_clk,
  input  wire logic    i_reset_n,
  eif_chan_if.chan     ifc
);

  typedef struct packed {
    logic [2:0] samp;
    logic       filt;
    logic       lvl;
    logic       req;
  } eif_chan_s;

  eif_chan_s r;
  eif_chan_s n;

  // true when the newest samples agree: three or two of them
  function automatic logic eif_agree(input logic [2:0] s, input logic three);
    if (three) begin
      eif_agree = (s == 3'h7) || (s == 3'h0);
    end else begin
      eif_agree = (s[1:0] == 2'h3) || (s[1:0] == 2'h0);
    end
  endfunction : eif_agree

  always_comb begin
    n = r;
    n.req = 1'b0;
    if (ifc.run && ifc.sample_en) begin
      n.samp = {r.samp[1:0], ifc.pin};
      if (eif_agree(n.samp, !FIXED && !ifc.slow)) begin
        n.filt = ifc.pin;
      end
    end
    if (ifc.run) begin
      unique case (ifc.trig)
        eif_pkg::TRIG_RISE: n.req = n.filt & ~r.filt;
        eif_pkg::TRIG_FALL: n.req = ~n.filt & r.filt;
        eif_pkg::TRIG_BOTH: n.req = n.filt ^ r.filt;
        eif_pkg::TRIG_HIGH: n.req = HIGH_OK & n.filt;
      endcase
    end
    if (n.req) begin
      n.lvl = n.filt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ifc.req   = r.req;
  assign ifc.level = r.lvl;

endmodule : eif_chan

// >>> eif_chan_if.sv
// carrier between the filter top and one source channel
`timescale 1ns/100ps
interface eif_chan_if;
  logic       sample_en;
  logic       run;
  logic       slow;
  logic       pin;
  logic [1:0] trig;
  logic       req;
  logic       level;

  modport top  (output sample_en, output run, output slow, output pin, output trig,
                input req, input level);
  modport chan (input sample_en, input run, input slow, input pin, input trig,
                output req, output level);
endinterface : eif_chan_if

// >>> eif_pin_board.sv
// board model: external interrupt pins and low-frequency tick
`timescale 1ns/100ps
module eif_pin_board #(
  parameter int LF_PER = 4
) (
  input  wire logic       i_ref_clk,
  output logic      [5:0] o_pin,
  output logic            o_lf_tick
);
  int lf_cnt = 0;
  initial begin
    o_pin = 6'h21;
    o_lf_tick = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    lf_cnt <= (lf_cnt == LF_PER - 1) ? 0 : lf_cnt + 1;
    o_lf_tick <= (lf_cnt == LF_PER - 1);
  end
  // hold one pin at a level for w cycles, then return it
  task automatic pulse(input int s, input logic v, input int w);
    o_pin[s] <= v;
    repeat (w) @(posedge i_ref_clk);
    o_pin[s] <= ~v;
  endtask : pulse
endmodule : eif_pin_board

// >>> eif_pkg.sv
// shared constants, register map and types of the external interrupt filter
package eif_pkg;

  localparam int NSRC = 6;
  localparam int WB_AW = 16;
  localparam int WB_DW = 32;

  // register indexes; byte address is four times the index
  localparam logic [13:0] CFG1_IDX  = 14'h0FD8;
  localparam logic [13:0] CFG2_IDX  = 14'h0FD9;
  localparam logic [13:0] CFG3_IDX  = 14'h0FDA;
  localparam logic [13:0] CFG4_IDX  = 14'h0FDB;
  localparam logic [13:0] PGATE_IDX = 14'h0FE0;
  localparam int IDX_LSB = 2;

  // configuration byte layout
  localparam int NC_LSB   = 0;
  localparam int TRIG_LSB = 2;
  localparam int LVL_BIT  = 4;
  localparam logic [2:0] CFG_RSVD_VAL = 3'h0;

  localparam logic [1:0] CFG_TRIG_RST = 2'h0;
  localparam logic [1:0] CFG_NC_RST   = 2'h0;
  localparam logic [NSRC-1:0] PGATE_RST = 6'h00;

  // trigger select codes
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
  localparam logic [1:0] TRIG_HIGH = 2'h3;

  // fast sampling interval codes and prescaler masks
  localparam logic [1:0] NC_DIV1  = 2'h0;
  localparam logic [1:0] NC_DIV4  = 2'h1;
  localparam logic [1:0] NC_DIV8  = 2'h2;
  localparam logic [1:0] NC_DIV16 = 2'h3;
  localparam logic [3:0] MASK_DIV1  = 4'h0;
  localparam logic [3:0] MASK_DIV4  = 4'h3;
  localparam logic [3:0] MASK_DIV8  = 4'h7;
  localparam logic [3:0] MASK_DIV16 = 4'hF;

  // low-frequency tick divider
  localparam logic [1:0] LF_DIV_LAST = 2'h3;

  typedef enum logic [2:0] {
    MODE_FAST_RUN,
    MODE_FAST_HALT,
    MODE_SLOW_RUN,
    MODE_SLOW_HALT,
    MODE_STOP
  } eif_mode_e;

endpackage : eif_pkg

// >>> eif_top.sv
// external interrupt input filter: wishbone registers and six source channels
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module eif_top (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [eif_pkg::WB_AW-1:0]   i_wb_adr,
  input  wire logic [3:0]                  i_wb_sel,
  input  wire logic [eif_pkg::WB_DW-1:0]   i_wb_dat,
  output logic      [eif_pkg::WB_DW-1:0]   o_wb_dat,
  output logic                             o_wb_ack,
  input  wire logic [eif_pkg::NSRC-1:0]    i_ext_pin,
  input  wire eif_pkg::eif_mode_e          i_op_mode,
  input  wire logic                        i_lf_tick,
  output logic      [eif_pkg::NSRC-1:0]    o_irq_req
);

  typedef struct packed {
    logic [4:1][1:0]                 trig;
    logic [4:1][1:0]                 nc;
    logic [eif_pkg::NSRC-1:0]        pgate;
    logic                            ack;
    logic [eif_pkg::WB_DW-1:0]       dat;
    logic [eif_pkg::NSRC-1:0]        irq;
    logic [3:0]                      pre;
    logic [1:0]                      lf_cnt;
  } eif_top_s;

  eif_top_s r;
  eif_top_s n;

  logic [eif_pkg::NSRC-1:0] req_w;
  logic [eif_pkg::NSRC-1:0] lvl_w;
  logic                     fast_mode;
  logic                     slow_mode;
  logic                     slow_en;

  // fast-mode sample enable from the gear-clock prescaler
  function automatic logic eif_fast_en(input logic [1:0] nc, input logic [3:0] pre);
    logic [3:0] mask;
    mask = eif_pkg::MASK_DIV1;
    unique case (nc)
      eif_pkg::NC_DIV1:  mask = eif_pkg::MASK_DIV1;
      eif_pkg::NC_DIV4:  mask = eif_pkg::MASK_DIV4;
      eif_pkg::NC_DIV8:  mask = eif_pkg::MASK_DIV8;
      eif_pkg::NC_DIV16: mask = eif_pkg::MASK_DIV16;
    endcase
    eif_fast_en = ((pre & mask) == 4'h0);
  endfunction : eif_fast_en

  // configuration byte as read back
  function automatic logic [7:0] eif_cfg_byte(input logic [1:0] trig, input logic [1:0] nc,
                                              input logic lvl);
    eif_cfg_byte = {eif_pkg::CFG_RSVD_VAL, lvl, trig, nc};
  endfunction : eif_cfg_byte

  // configuration register index of a programmable source
  function automatic logic [13:0] eif_cfg_idx(input int src);
    unique case (src)
      1:       eif_cfg_idx = eif_pkg::CFG1_IDX;
      2:       eif_cfg_idx = eif_pkg::CFG2_IDX;
      3:       eif_cfg_idx = eif_pkg::CFG3_IDX;
      default: eif_cfg_idx = eif_pkg::CFG4_IDX;
    endcase
  endfunction : eif_cfg_idx

  assign fast_mode = (i_op_mode == eif_pkg::MODE_FAST_RUN) ||
                     (i_op_mode == eif_pkg::MODE_FAST_HALT);
  assign slow_mode = (i_op_mode == eif_pkg::MODE_SLOW_RUN) ||
                     (i_op_mode == eif_pkg::MODE_SLOW_HALT);
  assign slow_en   = i_lf_tick && (r.lf_cnt == eif_pkg::LF_DIV_LAST);

  always_comb begin
    logic [13:0] idx;
    logic        take;
    idx  = i_wb_adr[eif_pkg::WB_AW-1:eif_pkg::IDX_LSB];
    take = i_wb_cyc && i_wb_stb;
    n = r;
    n.pre = r.pre + 4'h1;
    if (i_lf_tick) begin
      n.lf_cnt = r.lf_cnt + 2'h1;
    end
    n.irq = req_w;
    n.ack = take && !r.ack;
    if (take && !r.ack) begin
      n.dat = '0;
      for (int s = 1; s <= 4; s++) begin
        if (idx == eif_cfg_idx(s)) begin
          n.dat[7:0] = eif_cfg_byte(r.trig[s], r.nc[s], lvl_w[s]);
        end
      end
      if (idx == eif_pkg::PGATE_IDX) begin
        n.dat[eif_pkg::NSRC-1:0] = r.pgate;
      end
    end
    // a write lands at the edge where the master sees ack
    if (take && r.ack && i_wb_we && i_wb_sel[0]) begin
      for (int s = 1; s <= 4; s++) begin
        if (idx == eif_cfg_idx(s)) begin
          n.trig[s] = i_wb_dat[eif_pkg::TRIG_LSB +: 2];
          n.nc[s]   = i_wb_dat[eif_pkg::NC_LSB +: 2];
        end
      end
      if (idx == eif_pkg::PGATE_IDX) begin
        n.pgate = i_wb_dat[eif_pkg::NSRC-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      r       <= '0;
      r.trig  <= {4{eif_pkg::CFG_TRIG_RST}};
      r.nc    <= {4{eif_pkg::CFG_NC_RST}};
      r.pgate <= eif_pkg::PGATE_RST;
    end else begin
      r <= n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < eif_pkg::NSRC; g++) begin : g_src
      localparam bit FIX = (g == 0) || (g == eif_pkg::NSRC - 1);
      eif_chan_if u_if ();
      assign u_if.pin  = i_ext_pin[g];
      assign u_if.slow = slow_mode;
      assign u_if.run  = r.pgate[g] && (fast_mode || slow_mode);
      if (FIX) begin : g_fixed
        assign u_if.trig      = eif_pkg::TRIG_FALL;
        assign u_if.sample_en = fast_mode || slow_en;
      end else begin : g_prog
        assign u_if.trig      = r.trig[g];
        assign u_if.sample_en = fast_mode ? eif_fast_en(r.nc[g], r.pre) : slow_en;
      end
      assign req_w[g] = u_if.req;
      assign lvl_w[g] = u_if.level;
      eif_chan #(
        .FIXED   (FIX),
        .HIGH_OK (g == 4)
      ) u_chan (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .ifc       (u_if)
      );
    end
  endgenerate

  assign o_wb_dat  = r.dat;
  assign o_wb_ack  = r.ack;
  assign o_irq_req = r.irq;

endmodule : eif_top

// >>> eif_top_chk.sv
// port checker of the external interrupt filter
`timescale 1ns/100ps
module eif_top_chk (
  input wire logic               i_ref_clk,
  input wire logic               i_reset_n,
  input wire logic               i_wb_cyc,
  input wire logic               i_wb_stb,
  input wire logic               i_wb_we,
  input wire logic [15:0]        i_wb_adr,
  input wire logic [3:0]         i_wb_sel,
  input wire logic [31:0]        i_wb_dat,
  input wire logic [31:0]        o_wb_dat,
  input wire logic               o_wb_ack,
  input wire logic [5:0]         i_ext_pin,
  input wire eif_pkg::eif_mode_e i_op_mode,
  input wire logic               i_lf_tick,
  input wire logic [5:0]         o_irq_req
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic gate_seen_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      gate_seen_r <= 1'b0;
    end else if (o_wb_ack && i_wb_we && i_wb_adr[15:2] == eif_pkg::PGATE_IDX) begin
      gate_seen_r <= 1'b1;
    end
  end
  chk_ack_answer: assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack)
    else $error("ack late");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  chk_ack_in_cycle: assert property (o_wb_ack |-> i_wb_cyc && i_wb_stb)
    else $error("ack without request");
  chk_cfg4_zero: assert property (
    o_wb_ack && !i_wb_we && i_wb_adr[15:2] == eif_pkg::CFG4_IDX |-> o_wb_dat[31:5] == 27'h0)
    else $error("reserved bits set");
  chk_src0_fall: assert property ($rose(o_irq_req[0]) |-> !$past(i_ext_pin[0], 2))
    else $error("source 0 not on falling edge");
  chk_src5_fall: assert property ($rose(o_irq_req[5]) |-> !$past(i_ext_pin[5], 2))
    else $error("source 5 not on falling edge");
  chk_edge_pulse: assert property ((o_irq_req & $past(o_irq_req) & 6'h2F) == 6'h00)
    else $error("edge request longer than one cycle");
  chk_stop_quiet: assert property (
    $past(i_op_mode, 2) == eif_pkg::MODE_STOP && $past(i_op_mode, 3) == eif_pkg::MODE_STOP
    |-> o_irq_req == 6'h00) else $error("request in stop mode");
  chk_gate_reset: assert property (!gate_seen_r |-> o_irq_req == 6'h00)
    else $error("request before gate enable");
  cov_src4_req: cover property (o_irq_req[4]);
  cov_src0_req: cover property ($rose(o_irq_req[0]));
  cov_read: cover property (o_wb_ack && !i_wb_we);
endmodule : eif_top_chk
bind eif_top eif_top_chk chk (.i_ref_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ext_pin, .i_op_mode, .i_lf_tick, .o_irq_req);

// >>> tb.sv
// self-checking testbench of the external interrupt filter
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  logic               clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic               ack, tick;
  logic [5:0]         pin, irq;
  logic [15:0]        adr = 16'h0;
  logic [31:0]        wdat = 32'h0, rdat, q;
  eif_pkg::eif_mode_e mode = eif_pkg::MODE_FAST_RUN;
  int                 cnt[6] = '{default: 0}, base[6], bad_count = 0, samples_checked = 0;
  always #2 clk = ~clk;
  // count at the falling edge where requests are settled; an unknown counts as a request
  always @(negedge clk) for (int s = 0; s < 6; s++) cnt[s] += int'(irq[s] !== 1'b0);
  eif_pin_board pins (.i_ref_clk(clk), .o_pin(pin), .o_lf_tick(tick));
  eif_top dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ext_pin(pin), .i_op_mode(mode), .i_lf_tick(tick), .o_irq_req(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [13:0] idx, input logic [7:0] e, input string n);
    wb(1'b0, idx, 8'h00);
    `CHK(n, {24'h0, e}, q)
  endtask : rd
  task automatic ck(input int s, input int e, input int w);
    repeat (w) @(posedge clk);
    `CHK("request count", e, cnt[s] - base[s])
  endtask : ck
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(eif_pkg::CFG4_IDX, 8'h00, "cfg4 reset");
    rd(eif_pkg::PGATE_IDX, 8'h00, "gate reset");
    wb(1'b1, 14'h0123, 8'hFF);
    rd(14'h0123, 8'h00, "unmapped");
    base = cnt;
    pins.pulse(1, 1'b1, 12);
    pins.pulse(0, 1'b0, 12);
    ck(0, 0, 10);
    ck(1, 0, 0);
    wb(1'b1, eif_pkg::PGATE_IDX, 8'h3F);
    rd(eif_pkg::PGATE_IDX, 8'h3F, "gate");
    wb(1'b1, eif_pkg::CFG4_IDX, 8'hFF);
    rd(eif_pkg::CFG4_IDX, 8'h0F, "cfg4 bits");
    for (int c = 0; c < 3; c++) begin
      wb(1'b1, eif_pkg::CFG4_IDX, {4'h0, c[1:0], 2'h0});
      base = cnt;
      fork
        pins.pulse(4, 1'b1, 30);
        begin
          repeat (20) @(posedge clk);
          rd(eif_pkg::CFG4_IDX, {4'h1, c[1:0], 2'h0}, "level high");
        end
      join
      ck(4, (c == 2) ? 2 : 1, 10);
      rd(eif_pkg::CFG4_IDX, {3'h0, c == 0, c[1:0], 2'h0}, "level");
    end
    wb(1'b1, eif_pkg::CFG4_IDX, 8'h0C);
    base = cnt;
    pins.pulse(4, 1'b1, 20);
    repeat (10) @(posedge clk);
    `CHK("level requests", 20, cnt[4] - base[4])
    rd(eif_pkg::CFG4_IDX, 8'h1C, "level bit");
    for (int s = 1; s < 5; s++) begin
      wb(1'b1, eif_pkg::CFG1_IDX + 14'(s - 1), 8'(7 + s));
      base = cnt;
      pins.pulse(s, 1'b1, (s == 1) ? 1 : (1 << s));
      ck(s, 0, 60);
      pins.pulse(s, 1'b1, (s == 1) ? 5 : 3 * (1 << s) + 2);
      ck(s, 2, 60);
    end
    for (int s = 0; s < 6; s += 5) begin
      base = cnt;
      pins.pulse(s, 1'b0, 3);
      ck(s, 1, 6);
    end
    mode <= eif_pkg::MODE_SLOW_RUN;
    repeat (48) @(posedge clk);
    for (int s = 4; s < 6; s++) begin
      mode <= (s == 4) ? eif_pkg::MODE_SLOW_RUN : eif_pkg::MODE_SLOW_HALT;
      base = cnt;
      pins.pulse(s, s == 4, 15);
      ck(s, 0, 40);
      pins.pulse(s, s == 4, 34);
      ck(s, (s == 4) ? 2 : 1, 40);
    end
    mode <= eif_pkg::MODE_STOP;
    base = cnt;
    pins.pulse(1, 1'b1, 20);
    ck(1, 0, 20);
    mode <= eif_pkg::MODE_FAST_HALT;
    pins.pulse(1, 1'b1, 20);
    ck(1, 2, 20);
    wb(1'b1, eif_pkg::PGATE_IDX, 8'h3D);
    base = cnt;
    pins.pulse(1, 1'b1, 20);
    ck(1, 0, 20);
    complete_run();
  end
endmodule : tb
